// *** flash_status_pkg.sv ***
// Purpose: Constants shared by the flash status polling controller.
// Assumes: Status bits sit in the low data byte of the flash bus.
// Notes: Bus timing counts are in cycles of the 100 MHz ref_clk.
// Contract
// - On starting a toggle check the host reads the whole byte twice in a row and compares the toggle bits.
// - If the bit still toggles and the timing failure flag is high, the host checks the toggle bit once more.
// - If it still toggles on that recheck, the operation failed and the host writes the reset command.
// - If the host leaves polling for other work, it restarts from the first double read when it returns.
// - After any timing failure the host issues the reset command before array reads resume.
// - The host may skip the window flag only if added sector erases always come less than 50 us apart.
// - After a sector erase the host confirms acceptance by toggle bit and reads the window flag before and after each added sector.
// - Status reads carry a valid address: the programmed location or a sector chosen for erase.
package flash_status_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    // Status bit positions in the data byte.
    localparam int POS_POLL = 7;
    localparam int POS_TOGGLE = 6;
    localparam int POS_FAIL = 5;
    localparam int POS_WINDOW = 3;
    localparam int POS_SECT_TOGGLE = 2;
    // Bus cycle timing in ns and in derived clock cycles.
    localparam int CLK_NS = 10;
    localparam int READ_NS = 90;
    localparam int WRITE_NS = 50;
    localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int WRITE_CYC = (WRITE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;
    // Sector erase add spacing limit, rounded down.
    localparam int ADD_GAP_US = 50;
    localparam int ADD_GAP_CYC = ADD_GAP_US * 1000 / CLK_NS;
    // Reset command data, written to any address.
    localparam logic [7:0] RESET_CMD = 8'hF0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // Poll results reported to the user.
    typedef enum logic [1:0] {RES_NONE, RES_DONE, RES_FAIL,
        RES_ABORT} result_type;
endpackage

// *** flash_bus_cycle.sv ***
// Purpose: One timed read or write cycle on the flash parallel bus.
// Assumes: Data input is synchronous to ref_clk.
// Notes: Read data is captured on the last cycle of the strobe.
`timescale 1ns/1ns
`default_nettype none
module flash_bus_cycle (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire logic is_write,
    input wire logic [flash_status_pkg::DATA_W-1:0] wdata,
    input wire logic [flash_status_pkg::DATA_W-1:0] dq_in,
    output logic busy,
    output logic done,
    output logic [flash_status_pkg::DATA_W-1:0] rdata,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [flash_status_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe
);
    logic [flash_status_pkg::CNT_W-1:0] cnt, next_cnt;
    logic next_busy, next_done, next_ce_n, next_oe_n, next_we_n, next_dq_oe;
    logic [flash_status_pkg::DATA_W-1:0] next_rdata, next_dq_out;

    // Compute the strobe sequence of one cycle.
    always_comb begin
        next_cnt = cnt;
        next_busy = busy;
        next_done = 1'b0;
        next_rdata = rdata;
        next_ce_n = ce_n;
        next_oe_n = oe_n;
        next_we_n = we_n;
        next_dq_out = dq_out;
        next_dq_oe = dq_oe;
        if (!busy && start) begin
            next_busy = 1'b1;
            next_ce_n = 1'b0;
            next_oe_n = is_write;
            next_we_n = !is_write;
            next_dq_out = wdata;
            next_dq_oe = is_write;
            next_cnt = is_write ?
                flash_status_pkg::CNT_W'(flash_status_pkg::WRITE_CYC) :
                flash_status_pkg::CNT_W'(flash_status_pkg::READ_CYC);
        end else if (busy) begin
            if (cnt > flash_status_pkg::CNT_W'(1)) begin
                next_cnt = cnt - flash_status_pkg::CNT_W'(1);
            end else begin
                next_busy = 1'b0;
                next_done = 1'b1;
                next_ce_n = 1'b1;
                next_oe_n = 1'b1;
                next_we_n = 1'b1;
                next_dq_oe = 1'b0;
                if (!oe_n) begin
                    next_rdata = dq_in;
                end
            end
        end
    end

    // Register the cycle state.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            rdata <= '0;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            dq_out <= '0;
            dq_oe <= 1'b0;
        end else begin
            cnt <= next_cnt;
            busy <= next_busy;
            done <= next_done;
            rdata <= next_rdata;
            ce_n <= next_ce_n;
            oe_n <= next_oe_n;
            we_n <= next_we_n;
            dq_out <= next_dq_out;
            dq_oe <= next_dq_oe;
        end
    end
endmodule
`default_nettype wire

// *** flash_status_poller.sv ***
// Purpose: Host side toggle bit polling of a flash program or erase.
// Assumes: The user has already written the program or erase sequence.
// Notes: A failed operation is followed by an automatic reset command.
`timescale 1ns/1ns
`default_nettype none
module flash_status_poller (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic poll_start,
    input wire logic [flash_status_pkg::ADDR_W-1:0] poll_addr,
    input wire logic use_sector_toggle,
    input wire logic poll_abort,
    input wire logic window_check,
    input wire logic [flash_status_pkg::DATA_W-1:0] dq_in,
    output logic poll_busy,
    output logic poll_done,
    output flash_status_pkg::result_type poll_result,
    output logic window_valid,
    output logic window_open,
    output logic [flash_status_pkg::ADDR_W-1:0] addr,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [flash_status_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe
);
    typedef enum logic [2:0] {ST_IDLE, ST_FIRST, ST_SECOND, ST_RECHK,
        ST_RESET, ST_WIN, ST_END} state_type;

    state_type state, next_state;
    logic [flash_status_pkg::ADDR_W-1:0] next_addr;
    logic prev_bit, next_prev_bit;
    logic next_poll_busy, next_poll_done, next_window_valid;
    logic next_window_open;
    flash_status_pkg::result_type next_poll_result;
    logic cyc_start, cyc_write, cyc_busy, cyc_done;
    logic [flash_status_pkg::DATA_W-1:0] cyc_rdata;
    logic cur_bit, toggled, fail_high;

    flash_bus_cycle u_cycle (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .start(cyc_start),
        .is_write(cyc_write),
        .wdata(flash_status_pkg::RESET_CMD),
        .dq_in(dq_in),
        .busy(cyc_busy),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .ce_n(ce_n),
        .oe_n(oe_n),
        .we_n(we_n),
        .dq_out(dq_out),
        .dq_oe(dq_oe)
    );

    // Pick the watched toggle bit and compare it with the stored one.
    assign cur_bit = use_sector_toggle ?
        cyc_rdata[flash_status_pkg::POS_SECT_TOGGLE] :
        cyc_rdata[flash_status_pkg::POS_TOGGLE];
    assign toggled = cur_bit != prev_bit;
    assign fail_high = cyc_rdata[flash_status_pkg::POS_FAIL];

    // Start bus cycles from the states that need one.
    always_comb begin
        cyc_start = 1'b0;
        cyc_write = 1'b0;
        if (!cyc_busy && !cyc_done) begin
            case (state)
                ST_FIRST, ST_SECOND, ST_RECHK, ST_WIN: begin
                    cyc_start = 1'b1;
                end
                ST_RESET: begin
                    cyc_start = 1'b1;
                    cyc_write = 1'b1;
                end
                default: begin
                    cyc_start = 1'b0;
                end
            endcase
        end
    end

    // Walk the double read, recheck and failure recovery.
    always_comb begin
        next_state = state;
        next_addr = addr;
        next_prev_bit = prev_bit;
        next_poll_busy = poll_busy;
        next_poll_done = 1'b0;
        next_poll_result = poll_result;
        next_window_valid = window_valid;
        next_window_open = window_open;
        case (state)
            ST_IDLE: begin
                if (poll_start) begin
                    next_addr = poll_addr;
                    next_state = ST_FIRST;
                    next_poll_busy = 1'b1;
                    next_poll_result = flash_status_pkg::RES_NONE;
                end else if (window_check) begin
                    next_addr = poll_addr;
                    next_state = ST_WIN;
                    next_poll_busy = 1'b1;
                    next_window_valid = 1'b0;
                end
            end
            ST_FIRST: begin
                if (cyc_done) begin
                    next_prev_bit = cur_bit;
                    next_state = ST_SECOND;
                end
            end
            ST_SECOND: begin
                if (cyc_done) begin
                    next_prev_bit = cur_bit;
                    if (!toggled) begin
                        next_poll_result = flash_status_pkg::RES_DONE;
                        next_state = ST_END;
                    end else if (fail_high) begin
                        next_state = ST_RECHK;
                    end else if (poll_abort) begin
                        next_poll_result = flash_status_pkg::RES_ABORT;
                        next_state = ST_END;
                    end else begin
                        next_state = ST_SECOND;
                    end
                end
            end
            ST_RECHK: begin
                if (cyc_done) begin
                    if (toggled) begin
                        next_poll_result = flash_status_pkg::RES_FAIL;
                        next_state = ST_RESET;
                    end else begin
                        next_poll_result = flash_status_pkg::RES_DONE;
                        next_state = ST_END;
                    end
                end
            end
            ST_RESET: begin
                if (cyc_done) begin
                    next_state = ST_END;
                end
            end
            ST_WIN: begin
                if (cyc_done) begin
                    next_window_open =
                        !cyc_rdata[flash_status_pkg::POS_WINDOW];
                    next_window_valid = 1'b1;
                    next_state = ST_IDLE;
                    next_poll_busy = 1'b0;
                end
            end
            ST_END: begin
                next_poll_done = 1'b1;
                next_poll_busy = 1'b0;
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Register controller state.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            addr <= '0;
            prev_bit <= 1'b0;
            poll_busy <= 1'b0;
            poll_done <= 1'b0;
            poll_result <= flash_status_pkg::RES_NONE;
            window_valid <= 1'b0;
            window_open <= 1'b0;
        end else begin
            state <= next_state;
            addr <= next_addr;
            prev_bit <= next_prev_bit;
            poll_busy <= next_poll_busy;
            poll_done <= next_poll_done;
            poll_result <= next_poll_result;
            window_valid <= next_window_valid;
            window_open <= next_window_open;
        end
    end
endmodule
`default_nettype wire

// *** flash_status_poller_assertions.sv ***
// Purpose: Port timing checks for the flash status poller.
// Assumes: Strobe widths as set in the poller package.
// Notes: Read and write strobes are counted in helper logic.
`timescale 1ns/1ns
`default_nettype none
module flash_status_poller_chk (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic poll_start,
    input wire logic poll_busy,
    input wire logic poll_done,
    input wire flash_status_pkg::result_type poll_result,
    input wire logic window_check,
    input wire logic window_valid,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [flash_status_pkg::DATA_W-1:0] dq_out,
    input wire logic dq_oe
);
    logic oe_q, we_q;
    logic [7:0] reads, writes, rd_low;
    // Counts strobes since the last accepted poll request.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            oe_q <= 1'b1;
            we_q <= 1'b1;
            reads <= 8'h00;
            writes <= 8'h00;
            rd_low <= 8'h00;
        end else begin
            oe_q <= oe_n;
            // Length of the current read strobe, both selects low.
            if (!oe_n && !ce_n) begin
                rd_low <= rd_low + 8'h01;
            end else begin
                rd_low <= 8'h00;
            end
            we_q <= we_n;
            if (poll_start && !poll_busy) begin
                reads <= 8'h00;
                writes <= 8'h00;
            end else begin
                reads <= reads + {7'h00, oe_q & ~oe_n};
                writes <= writes + {7'h00, we_q & ~we_n};
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // The two bus cycles, each a held strobe then release.
    // A read ends with both selects released after the full strobe count.
    sequence s_read;
        rd_low == 8'(flash_status_pkg::READ_CYC) && ce_n;
    endsequence
    sequence s_reset_write;
        (!we_n && dq_oe && dq_out == flash_status_pkg::RESET_CMD) [*5]
            ##1 we_n;
    endsequence
    property p_read_len;
        $rose(oe_n) |-> s_read;
    endproperty
    property p_reset_write;
        $fell(we_n) |-> s_reset_write;
    endproperty
    property p_start;
        poll_start && !poll_busy |=> poll_busy ##[1:3] !oe_n;
    endproperty
    property p_two_reads;
        poll_done |-> reads >= 8'h02;
    endproperty
    property p_fail_recheck;
        poll_done && poll_result == flash_status_pkg::RES_FAIL
            |-> reads >= 8'h03 && writes == 8'h01;
    endproperty
    property p_done_clean;
        poll_done && poll_result != flash_status_pkg::RES_FAIL
            |-> writes == 8'h00;
    endproperty
    property p_no_clash;
        dq_oe |-> oe_n;
    endproperty
    property p_window;
        window_check && !poll_start && !poll_busy
            |-> ##[1:2] !window_valid ##[1:16] window_valid;
    endproperty
    a_read_len: assert property (p_read_len) else $error("read width");
    a_reset_write: assert property (p_reset_write) else $error("wr");
    a_start: assert property (p_start) else $error("start late");
    a_two_reads: assert property (p_two_reads) else $error("one read");
    a_fail_recheck: assert property (p_fail_recheck) else $error("f");
    a_done_clean: assert property (p_done_clean) else $error("wr");
    a_no_clash: assert property (p_no_clash) else $error("clash");
    a_window: assert property (p_window) else $error("window");
endmodule
bind flash_status_poller flash_status_poller_chk chk_u (
    .ref_clk(ref_clk), .arst_n(arst_n), .poll_start(poll_start),
    .poll_busy(poll_busy), .poll_done(poll_done),
    .poll_result(poll_result), .window_check(window_check),
    .window_valid(window_valid), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .dq_out(dq_out), .dq_oe(dq_oe)
);
`default_nettype wire

// *** flash_device_model.sv ***
// Purpose: Behavioural flash device answering status reads.
// Assumes: Testbench loads each algorithm before polling.
// Notes: Deselected data shows the inverse of the last byte.
`timescale 1ns/1ns
`default_nettype none
module flash_device_model #(
    parameter logic [7:0] SECT = 8'h3C,
    parameter logic [7:0] ARRAY = 8'h5A
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [19:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe,
    input wire logic load,
    input wire logic [7:0] load_reads,
    input wire logic load_fail,
    input wire logic [15:0] load_win,
    output logic [7:0] dq_in,
    output logic in_alg
);
    logic tog, stog, fail, fail_arm, oe_q;
    logic [7:0] left, last;
    logic [15:0] win;
    // Status byte while busy, array data once finished.
    always_comb begin
        if (ce_n || oe_n)
            dq_in = ~last;
        else if (in_alg)
            dq_in = {~ARRAY[7], tog, fail, 1'b0, win == 16'h0000, stog,
                2'b00};
        else
            dq_in = ARRAY;
    end
    // Advances the algorithm once per read strobe.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            {in_alg, tog, stog, fail, fail_arm} <= 5'h00;
            oe_q <= 1'b1;
            left <= 8'h00;
            last <= 8'h00;
            win <= 16'h0000;
        end else begin
            oe_q <= oe_n;
            if (!ce_n && !oe_n)
                last <= dq_in;
            if (win != 16'h0000)
                win <= win - 16'h0001;
            if (load) begin
                {in_alg, fail, fail_arm} <= {2'b10, load_fail};
                left <= load_reads;
                win <= load_win;
            end else if (oe_q && !oe_n && !ce_n && in_alg) begin
                tog <= ~tog;
                if (addr[19:12] == SECT)
                    stog <= ~stog;
                if (left != 8'h00)
                    left <= left - 8'h01;
                else if (fail_arm)
                    fail <= 1'b1;
                else
                    in_alg <= 1'b0;
            end else if (!we_n && dq_oe && dq_out == 8'hF0 && fail) begin
                in_alg <= 1'b0;
                fail <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** flash_status_poller_tb.sv ***
// Purpose: Self-checking bench for the flash status poller.
// Assumes: The device model answers every bus cycle.
// Notes: Expected results are queued as each poll is issued.
`timescale 1ns/1ns
`default_nettype none
module flash_status_poller_tb;
    localparam logic [7:0] SECT = 8'h3C;
    logic ref_clk = 1'b0, arst_n = 1'b0, poll_start = 1'b0, load = 1'b0;
    logic use_sector_toggle = 1'b0, poll_abort = 1'b0, load_fail = 1'b0;
    logic window_check = 1'b0, f, s;
    logic [19:0] poll_addr = 20'h00000, addr;
    logic [7:0] load_reads = 8'h00, dq_in, dq_out;
    logic [15:0] load_win = 16'h0000;
    logic poll_busy, poll_done, window_valid, window_open;
    logic ce_n, oe_n, we_n, dq_oe, in_alg;
    flash_status_pkg::result_type poll_result, exp_q[$];
    int bad_count = 0, num_checks = 0, rd_cnt = 0, i, n;
    always #5 ref_clk = ~ref_clk;
    always @(negedge oe_n) rd_cnt++;
    flash_status_poller dut_u (.ref_clk(ref_clk), .arst_n(arst_n),
        .poll_start(poll_start), .poll_addr(poll_addr),
        .use_sector_toggle(use_sector_toggle), .poll_abort(poll_abort),
        .window_check(window_check), .dq_in(dq_in), .poll_busy(poll_busy),
        .poll_done(poll_done), .poll_result(poll_result),
        .window_valid(window_valid), .window_open(window_open),
        .addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .dq_out(dq_out), .dq_oe(dq_oe));
    flash_device_model #(.SECT(SECT)) dev_u (.ref_clk(ref_clk),
        .arst_n(arst_n), .addr(addr), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .dq_out(dq_out), .dq_oe(dq_oe), .load(load),
        .load_reads(load_reads), .load_fail(load_fail),
        .load_win(load_win), .dq_in(dq_in), .in_alg(in_alg));
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Starts a new algorithm in the device model.
    task automatic arm(input int r, input logic fl, input int w);
        @(posedge ref_clk);
        load <= 1'b1;
        load_reads <= 8'(r);
        load_fail <= fl;
        load_win <= 16'(w);
        @(posedge ref_clk);
        load <= 1'b0;
    endtask
    task automatic poll(input logic [19:0] a, input logic st,
        input logic ab, input flash_status_pkg::result_type e);
        @(posedge ref_clk);
        poll_addr <= a;
        use_sector_toggle <= st;
        poll_abort <= ab;
        poll_start <= 1'b1;
        rd_cnt = 0;
        exp_q.push_back(e);
        @(posedge ref_clk);
        poll_start <= 1'b0;
        i = 0;
        do @(negedge ref_clk); while (poll_done !== 1'b1 && ++i < 3000);
        check("poll_done", poll_done, 1'b1);
        check("poll_result", poll_result, exp_q.pop_front());
        check("addr", addr, a);
        check("poll_busy", poll_busy, 1'b0);
    endtask
    task automatic win(input logic e);
        @(posedge ref_clk);
        window_check <= 1'b1;
        @(posedge ref_clk);
        window_check <= 1'b0;
        i = 0;
        do @(negedge ref_clk); while (window_valid !== 1'b1 && ++i < 100);
        check("window_valid", window_valid, 1'b1);
        check("window_open", window_open, e);
    endtask
    // Runs the scenarios in order and reports the verdict.
    initial begin
        void'($urandom(32'h229F));
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        for (int t = 0; t < 6; t++) begin
            n = $urandom_range(6, 1);
            f = 1'($urandom_range(1, 0));
            s = 1'($urandom_range(1, 0));
            arm(n, f, 0);
            poll({SECT, 12'($urandom)}, s, 1'b0, f ? flash_status_pkg::RES_FAIL
                : flash_status_pkg::RES_DONE);
            check("in_alg", in_alg, 1'b0);
        end
        $display("test random_polls done");
        arm(4, 1'b0, 0);
        poll(20'h00000, 1'b1, 1'b0, flash_status_pkg::RES_DONE);
        check("reads_outside", rd_cnt, 2);
        arm(4, 1'b0, 0);
        poll(20'h00000, 1'b0, 1'b0, flash_status_pkg::RES_DONE);
        check("reads_any_addr", rd_cnt > 4, 1'b1);
        arm(8, 1'b0, 0);
        poll({SECT, 12'h000}, 1'b0, 1'b1, flash_status_pkg::RES_ABORT);
        poll({SECT, 12'h000}, 1'b0, 1'b0, flash_status_pkg::RES_DONE);
        arm(3, 1'b1, 0);
        poll({SECT, 12'h123}, 1'b0, 1'b0, flash_status_pkg::RES_FAIL);
        check("in_alg_fail", in_alg, 1'b0);
        $display("test toggle_abort done");
        arm(200, 1'b0, 400);
        win(1'b1);
        repeat (400) @(posedge ref_clk);
        win(1'b0);
        arm(200, 1'b0, 400);
        win(1'b1);
        arm(50, 1'b0, 0);
        win(1'b0);
        $display("test erase_window done");
        summarize();
    end
    // Cuts a hung run short.
    initial begin
        #200000;
        bad_count++;
        summarize();
    end
endmodule
`default_nettype wire
